// >>> hdl/tcc_pkg.sv
// Purpose: constants, register map and mode types of the timer/counter block
// Assumes: 8-bit register bus, 16-bit counter, one system clock
// Notes: addresses are byte addresses on the 8-bit bus
package tcc_pkg;

  // window of the shared 8-bit map owned by this block
  localparam logic [7:0] ADDR_FIRST = 8'h5E;
  localparam logic [7:0] ADDR_LAST = 8'h6F;

  // register offsets
  localparam logic [7:0] OFF_CLOCK_SOURCE_CTRL = 8'h5E;
  localparam logic [7:0] OFF_MODE_CTRL = 8'h5F;
  localparam logic [7:0] OFF_TOP_LOW = 8'h60;
  localparam logic [7:0] OFF_TOP_HIGH = 8'h61;
  localparam logic [7:0] OFF_COMPARE_LOW = 8'h62;
  localparam logic [7:0] OFF_COMPARE_HIGH = 8'h63;
  localparam logic [7:0] OFF_COUNT_LOW = 8'h64;
  localparam logic [7:0] OFF_COUNT_HIGH = 8'h65;
  localparam logic [7:0] OFF_CAPTURE_LOW = 8'h66;
  localparam logic [7:0] OFF_CAPTURE_HIGH = 8'h67;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h68;
  localparam logic [7:0] OFF_IRQ_ENABLES = 8'h69;

  // field positions
  localparam int SRC_BIT = 0;
  localparam int EDGE_BIT = 1;
  localparam int CAPT_EN_BIT = 2;
  localparam int MODE_LSB = 0;
  localparam int OUTF_LSB = 2;
  localparam int DIV_LSB = 4;
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_CMP_BIT = 1;
  localparam int IRQ_CAPT_BIT = 2;

  // divider select codes and terminal counts (divide minus one)
  localparam logic [2:0] DIV_SEL_STOP = 3'h0;
  localparam logic [2:0] DIV_SEL_1 = 3'h1;
  localparam logic [2:0] DIV_SEL_8 = 3'h2;
  localparam logic [2:0] DIV_SEL_64 = 3'h3;
  localparam logic [2:0] DIV_SEL_256 = 3'h4;
  localparam logic [2:0] DIV_SEL_1024 = 3'h5;
  localparam logic [9:0] DIV_TERM_1 = 10'h000;
  localparam logic [9:0] DIV_TERM_8 = 10'h007;
  localparam logic [9:0] DIV_TERM_64 = 10'h03F;
  localparam logic [9:0] DIV_TERM_256 = 10'h0FF;
  localparam logic [9:0] DIV_TERM_1024 = 10'h3FF;

  // values after reset, also the configuration data when no bus is present
  localparam logic [7:0] RST_CLOCK_SOURCE_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL = 8'h10;
  localparam logic [15:0] RST_TOP = 16'hFFFF;
  localparam logic [15:0] RST_COMPARE = 16'h0000;
  localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    CLEAR_ON_TOP_MODE,
    EXPIRY_MODE,
    SINGLE_SLOPE_PWM_MODE,
    DUAL_SLOPE_PWM_MODE
  } tcc_mode_t;

  typedef enum logic [1:0] {
    OUT_HELD_LOW,
    OUT_TOGGLE,
    WAVEFORM_OUT,
    INVERTED_WAVEFORM_OUT
  } tcc_outf_t;

  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } tcc_dir_t;

endpackage

// >>> hdl/tcc_edge_det.sv
// Purpose: sample a slow pin on the system clock and flag its edges
// Assumes: pin toggles slower than half the system clock
// Notes: edge pulses lag the pin by three system clock edges
`timescale 1ns/1ps
module tcc_edge_det
  import tcc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_sig,
  output logic o_rise,
  output logic o_fall
);

  logic sync_a;
  logic sync_b;
  logic prev;

  // first stage is read only by the second stage
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      sync_a <= i_sig;
      sync_b <= sync_a;
      prev <= sync_b;
      o_rise <= sync_b & ~prev;
      o_fall <= ~sync_b & prev;
    end
  end

endmodule

// >>> hdl/tcc_prescale.sv
// Purpose: divide counter clock edges into counter ticks
// Assumes: one edge pulse per selected source edge
// Notes: select zero or an unused code stops all ticks
`timescale 1ns/1ps
module tcc_prescale
  import tcc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_edge,
  input wire logic [2:0] i_sel,
  input wire logic i_clear,
  output logic o_tick
);

  logic [9:0] div_cnt;
  logic [9:0] term;
  logic run;
  logic at_term;

  // terminal count of the chosen divider
  assign run = (i_sel >= DIV_SEL_1) && (i_sel <= DIV_SEL_1024);
  assign term = (i_sel == DIV_SEL_8) ? DIV_TERM_8 :
                (i_sel == DIV_SEL_64) ? DIV_TERM_64 :
                (i_sel == DIV_SEL_256) ? DIV_TERM_256 :
                (i_sel == DIV_SEL_1024) ? DIV_TERM_1024 : DIV_TERM_1;
  assign at_term = (div_cnt >= term);

  // divider chain; a stopped divider holds its count and emits nothing
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_cnt <= 10'h000;
      o_tick <= 1'b0;
    end else if (i_clear) begin
      div_cnt <= 10'h000;
      o_tick <= 1'b0;
    end else begin
      o_tick <= run && i_edge && at_term;
      if (run && i_edge) begin
        div_cnt <= at_term ? 10'h000 : div_cnt + 10'h001;
      end
    end
  end

endmodule

// >>> hdl/tcc_timer.sv
// Purpose: 16-bit timer/counter with mode, output function and interrupts
// Assumes: 8-bit bus master on the system clock; clock pins are slow levels
// Notes: with BUS_USED at zero the registers keep their configuration values
`timescale 1ns/1ps
module tcc_timer
  import tcc_pkg::*;
#(
  parameter bit BUS_USED = 1'b1,
  parameter logic [7:0] CFG_CLOCK_SOURCE_CTRL = RST_CLOCK_SOURCE_CTRL,
  parameter logic [7:0] CFG_MODE_CTRL = RST_MODE_CTRL,
  parameter logic [15:0] CFG_TOP = RST_TOP,
  parameter logic [15:0] CFG_COMPARE = RST_COMPARE,
  parameter logic [7:0] CFG_IRQ_ENABLES = RST_IRQ_ENABLES
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [7:0] I_WB_DAT,
  output logic [7:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_TIMER_CLOCK_IN,
  input wire logic I_OSC_CLK,
  input wire logic I_TIMER_RESET_LOW_N,
  input wire logic I_CAPTURE_TRIGGER_IN,
  output logic O_TIMER_OUTPUT,
  output logic O_TIMER_IRQ_OUT
);

  // address match shared by every register decode
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = (adr == off);
  endfunction

  // registers
  logic [7:0] clock_source_ctrl;
  logic [7:0] mode_output_prescale_ctrl;
  logic [7:0] top_value_high;
  logic [7:0] top_value_low;
  logic [7:0] compare_value_high;
  logic [7:0] compare_value_low;
  logic [7:0] irq_enables;
  logic [2:0] irq_flags;
  logic [15:0] active_top_value;
  logic [15:0] active_compare_value;
  logic [15:0] counter_value;
  logic [15:0] captured_count;
  tcc_dir_t dir;
  logic wave;

  // next values
  logic [15:0] next_count;
  logic [15:0] next_top;
  logic [15:0] next_compare;
  tcc_dir_t next_dir;
  logic next_wave;
  logic overflow_flag;
  logic compare_match_flag;
  logic capture_event_flag;

  // field views
  tcc_mode_t count_mode_field;
  tcc_outf_t output_function_field;
  logic [2:0] divider_select;
  logic clock_source_select;
  logic clock_edge_select;
  logic capture_enable;
  logic [15:0] top_value_staging;
  logic [15:0] compare_value_staging;

  assign count_mode_field = tcc_mode_t'(mode_output_prescale_ctrl[MODE_LSB +: 2]);
  assign output_function_field = tcc_outf_t'(mode_output_prescale_ctrl[OUTF_LSB +: 2]);
  assign divider_select = mode_output_prescale_ctrl[DIV_LSB +: 3];
  assign clock_source_select = clock_source_ctrl[SRC_BIT];
  assign clock_edge_select = clock_source_ctrl[EDGE_BIT];
  assign capture_enable = clock_source_ctrl[CAPT_EN_BIT];
  // high byte register carries bits 15:8
  assign top_value_staging = {top_value_high, top_value_low};
  assign compare_value_staging = {compare_value_high, compare_value_low};

  // edge detection of the two clock sources and the capture pin
  logic user_rise;
  logic user_fall;
  logic osc_rise;
  logic osc_fall;
  logic capt_rise;

  tcc_edge_det u_user_clk (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_sig(I_TIMER_CLOCK_IN),
    .o_rise(user_rise),
    .o_fall(user_fall)
  );

  tcc_edge_det u_osc_clk (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_sig(I_OSC_CLK),
    .o_rise(osc_rise),
    .o_fall(osc_fall)
  );

  tcc_edge_det u_capture (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_sig(I_CAPTURE_TRIGGER_IN),
    .o_rise(capt_rise),
    .o_fall()
  );

  // four-way pick of source and edge
  logic user_clk_rising;
  logic user_clk_falling;
  logic osc_clk_rising;
  logic osc_clk_falling;
  logic src_edge;

  assign user_clk_rising = !clock_source_select && !clock_edge_select && user_rise;
  assign user_clk_falling = !clock_source_select && clock_edge_select && user_fall;
  assign osc_clk_rising = clock_source_select && !clock_edge_select && osc_rise;
  assign osc_clk_falling = clock_source_select && clock_edge_select && osc_fall;
  assign src_edge = user_clk_rising | user_clk_falling | osc_clk_rising |
                    osc_clk_falling;

  // divider; the timer reset pin also restarts it so the first period is whole
  logic tick;

  tcc_prescale u_prescale (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_edge(src_edge),
    .i_sel(divider_select),
    .i_clear(!I_TIMER_RESET_LOW_N),
    .o_tick(tick)
  );

  // match terms
  logic top_match;
  logic cmp_match;
  logic pwm_mode;
  assign top_match = (counter_value == active_top_value);
  assign cmp_match = (counter_value == active_compare_value);
  assign pwm_mode = (count_mode_field == SINGLE_SLOPE_PWM_MODE) ||
                    (count_mode_field == DUAL_SLOPE_PWM_MODE);

  // count sequence, value reload and event pulses per mode
  always_comb begin
    next_count = counter_value;
    next_top = active_top_value;
    next_compare = active_compare_value;
    next_dir = dir;
    overflow_flag = 1'b0;
    compare_match_flag = 1'b0;
    if (tick) begin
      compare_match_flag = cmp_match;
      case (count_mode_field)
        DUAL_SLOPE_PWM_MODE: begin
          case (dir)
            DIR_UP: begin
              if (top_match || counter_value > active_top_value) begin
                next_dir = DIR_DOWN;
                next_count = counter_value - COUNT_ONE;
              end else begin
                next_count = counter_value + COUNT_ONE;
              end
            end
            DIR_DOWN: begin
              if (counter_value == COUNT_ONE || counter_value == COUNT_ZERO) begin
                // reload on the way into zero keeps the period symmetric
                next_count = COUNT_ZERO;
                next_dir = DIR_UP;
                next_top = top_value_staging;
                next_compare = compare_value_staging;
                overflow_flag = 1'b1;
              end else begin
                next_count = counter_value - COUNT_ONE;
              end
            end
            default: begin
              next_dir = DIR_UP;
            end
          endcase
        end
        default: begin
          next_dir = DIR_UP;
          if (top_match) begin
            next_count = COUNT_ZERO;
            next_top = top_value_staging;
            next_compare = compare_value_staging;
            overflow_flag = 1'b1;
          end else begin
            next_count = counter_value + COUNT_ONE;
          end
        end
      endcase
    end
  end

  // output function; toggle follows top in plain counting, compare in pwm
  always_comb begin
    next_wave = wave;
    if (tick) begin
      case (output_function_field)
        OUT_TOGGLE: begin
          if (pwm_mode ? cmp_match : top_match) begin
            next_wave = ~wave;
          end
        end
        WAVEFORM_OUT, INVERTED_WAVEFORM_OUT: begin
          if (count_mode_field == DUAL_SLOPE_PWM_MODE) begin
            if (cmp_match) begin
              next_wave = (dir == DIR_UP); // set going up, clear going down
            end
          end else if (top_match) begin
            next_wave = 1'b0;
          end else if (cmp_match) begin
            next_wave = 1'b1;
          end
        end
        default: begin
          next_wave = 1'b0;
        end
      endcase
    end
  end

  // capture only outside the pwm modes
  assign capture_event_flag = capture_enable && !pwm_mode && capt_rise;

  // counter state; the timer reset pin clears count and direction only
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      counter_value <= COUNT_ZERO;
      dir <= DIR_UP;
      wave <= 1'b0;
      active_top_value <= CFG_TOP;
      active_compare_value <= CFG_COMPARE;
    end else if (!I_TIMER_RESET_LOW_N) begin
      counter_value <= COUNT_ZERO;
      dir <= DIR_UP;
    end else begin
      counter_value <= next_count;
      dir <= next_dir;
      wave <= next_wave;
      active_top_value <= next_top;
      active_compare_value <= next_compare;
    end
  end

  // captured count for the bus
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      captured_count <= COUNT_ZERO;
    end else if (capture_event_flag) begin
      captured_count <= counter_value;
    end
  end

  // timer output pin; held-low wins over any pending waveform state
  logic next_pin;
  assign next_pin = (output_function_field == OUT_HELD_LOW) ? 1'b0 :
                    (output_function_field == INVERTED_WAVEFORM_OUT) ? ~wave : wave;

  // bus access; one-cycle ack for addresses inside this block's window
  logic bus_req;
  logic in_window;
  logic wr;
  assign in_window = (I_WB_ADR >= ADDR_FIRST) && (I_WB_ADR <= ADDR_LAST);
  assign bus_req = BUS_USED && I_WB_CYC && I_WB_STB && in_window && !O_WB_ACK;
  assign wr = bus_req && I_WB_WE;

  // write-one-to-clear with hardware set winning the same cycle
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  assign irq_set[IRQ_OVF_BIT] = overflow_flag && irq_enables[IRQ_OVF_BIT];
  assign irq_set[IRQ_CMP_BIT] = compare_match_flag && irq_enables[IRQ_CMP_BIT];
  assign irq_set[IRQ_CAPT_BIT] = capture_event_flag && irq_enables[IRQ_CAPT_BIT];
  assign irq_clr = (wr && reg_hit(I_WB_ADR, OFF_IRQ_FLAGS)) ? I_WB_DAT[2:0] : 3'h0;

  // read data selection
  logic [7:0] rd_data;
  assign rd_data =
    reg_hit(I_WB_ADR, OFF_CLOCK_SOURCE_CTRL) ? clock_source_ctrl :
    reg_hit(I_WB_ADR, OFF_MODE_CTRL) ? mode_output_prescale_ctrl :
    reg_hit(I_WB_ADR, OFF_TOP_LOW) ? top_value_low :
    reg_hit(I_WB_ADR, OFF_TOP_HIGH) ? top_value_high :
    reg_hit(I_WB_ADR, OFF_COMPARE_LOW) ? compare_value_low :
    reg_hit(I_WB_ADR, OFF_COMPARE_HIGH) ? compare_value_high :
    reg_hit(I_WB_ADR, OFF_COUNT_LOW) ? counter_value[7:0] :
    reg_hit(I_WB_ADR, OFF_COUNT_HIGH) ? counter_value[15:8] :
    reg_hit(I_WB_ADR, OFF_CAPTURE_LOW) ? captured_count[7:0] :
    reg_hit(I_WB_ADR, OFF_CAPTURE_HIGH) ? captured_count[15:8] :
    reg_hit(I_WB_ADR, OFF_IRQ_FLAGS) ? {5'h00, irq_flags} :
    reg_hit(I_WB_ADR, OFF_IRQ_ENABLES) ? irq_enables : 8'h00;

  // control registers; without the bus these keep the configuration data
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      clock_source_ctrl <= CFG_CLOCK_SOURCE_CTRL;
      mode_output_prescale_ctrl <= CFG_MODE_CTRL;
      irq_enables <= CFG_IRQ_ENABLES;
    end else if (wr) begin
      if (reg_hit(I_WB_ADR, OFF_CLOCK_SOURCE_CTRL)) begin
        clock_source_ctrl <= I_WB_DAT;
      end
      if (reg_hit(I_WB_ADR, OFF_MODE_CTRL)) begin
        mode_output_prescale_ctrl <= I_WB_DAT;
      end
      if (reg_hit(I_WB_ADR, OFF_IRQ_ENABLES)) begin
        irq_enables <= I_WB_DAT;
      end
    end
  end

  // staging registers for top and compare
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      top_value_high <= CFG_TOP[15:8];
      top_value_low <= CFG_TOP[7:0];
      compare_value_high <= CFG_COMPARE[15:8];
      compare_value_low <= CFG_COMPARE[7:0];
    end else if (wr) begin
      if (reg_hit(I_WB_ADR, OFF_TOP_HIGH)) begin
        top_value_high <= I_WB_DAT;
      end
      if (reg_hit(I_WB_ADR, OFF_TOP_LOW)) begin
        top_value_low <= I_WB_DAT;
      end
      if (reg_hit(I_WB_ADR, OFF_COMPARE_HIGH)) begin
        compare_value_high <= I_WB_DAT;
      end
      if (reg_hit(I_WB_ADR, OFF_COMPARE_LOW)) begin
        compare_value_low <= I_WB_DAT;
      end
    end
  end

  // sticky interrupt flags
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      irq_flags <= 3'h0;
    end else begin
      irq_flags <= (irq_flags & ~irq_clr) | irq_set;
    end
  end

  // bus answer and pins; standalone use reports overflow alone
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 8'h00;
      O_TIMER_OUTPUT <= 1'b0;
      O_TIMER_IRQ_OUT <= 1'b0;
    end else begin
      O_WB_ACK <= bus_req;
      O_WB_DAT <= bus_req ? rd_data : 8'h00;
      O_TIMER_OUTPUT <= next_pin;
      O_TIMER_IRQ_OUT <= BUS_USED ? (|(irq_flags & ~irq_clr | irq_set)) :
                         overflow_flag;
    end
  end

endmodule

// >>> testbench/tcc_wb_master.sv
// Purpose: bus master standing in for user logic
// Assumes: ack is a one-cycle pulse one cycle after the taking edge
// Notes: released lines show inverted values so stale data never matches
`timescale 1ns/1ps
module tcc_wb_master (
  input wire logic i_clk,
  input wire logic i_ack,
  input wire logic [7:0] i_dat,
  output logic o_cyc,
  output logic o_stb,
  output logic o_we,
  output logic [7:0] o_adr,
  output logic [7:0] o_dat
);
  // idle bus from time zero
  initial begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we = 1'b0;
    o_adr = 8'h00;
    o_dat = 8'h00;
  end

  // request held through the edge that samples ack, released after it
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [7:0] wd,
                      output logic [7:0] rd, output bit ok);
    ok = 1'b0;
    rd = 8'h00;
    @(negedge i_clk);
    o_cyc = 1'b1;
    o_stb = 1'b1;
    o_we = wr;
    o_adr = adr;
    o_dat = wr ? wd : ~o_dat;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge i_clk);
      if (i_ack === 1'b1) begin
        ok = 1'b1;
        rd = i_dat;
      end
    end
    @(negedge i_clk);
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_adr = ~o_adr;
    o_dat = ~o_dat;
  endtask
endmodule

// >>> testbench/tcc_timer_sva.sv
// Purpose: port checker for the timer block
// Assumes: control bytes change only through bus writes
// Notes: shadows copy writes so output and read data can be judged
`timescale 1ns/1ps
module tcc_timer_sva
  import tcc_pkg::*;
#(
  parameter bit BUS_USED = 1'b1
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [7:0] I_WB_DAT,
  input wire logic [7:0] O_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic O_TIMER_OUTPUT,
  input wire logic O_TIMER_IRQ_OUT
);
  logic take, wr, w1c, rd_q;
  logic [7:0] ra, mode_sh, en_sh;
  // request decode, same window the block answers
  assign take = I_WB_CYC && I_WB_STB && !O_WB_ACK && BUS_USED &&
                I_WB_ADR >= ADDR_FIRST && I_WB_ADR <= ADDR_LAST;
  assign wr = take && I_WB_WE;
  assign w1c = wr && I_WB_ADR == OFF_IRQ_FLAGS && I_WB_DAT != 8'h00;
  // shadows of the mode and enable bytes and the pending read address
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ra <= 8'h00;
      rd_q <= 1'b0;
      mode_sh <= RST_MODE_CTRL;
      en_sh <= RST_IRQ_ENABLES;
    end else begin
      ra <= take ? I_WB_ADR : ra;
      rd_q <= take && !I_WB_WE;
      mode_sh <= (wr && I_WB_ADR == OFF_MODE_CTRL) ? I_WB_DAT : mode_sh;
      en_sh <= (wr && I_WB_ADR == OFF_IRQ_ENABLES) ? I_WB_DAT : en_sh;
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);
  sequence s_take;
    take;
  endsequence
  sequence s_answer;
    O_WB_ACK ##1 !O_WB_ACK;
  endsequence
  property p_ack_timing;
    s_take |=> s_answer;
  endproperty
  a_ack_timing: assert property (p_ack_timing)
    else $error("ack not a single pulse after request");
  property p_ack_cause;
    O_WB_ACK |-> $past(take);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_dat_idle;
    !O_WB_ACK |-> O_WB_DAT == 8'h00;
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
  property p_mode_read;
    O_WB_ACK && rd_q && ra == OFF_MODE_CTRL |-> O_WB_DAT == mode_sh;
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode byte read wrong");
  property p_en_read;
    O_WB_ACK && rd_q && ra == OFF_IRQ_ENABLES |-> O_WB_DAT == en_sh;
  endproperty
  a_en_read: assert property (p_en_read)
    else $error("enable byte read wrong");
  property p_unmapped;
    O_WB_ACK && rd_q && ra > OFF_IRQ_ENABLES |-> O_WB_DAT == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_held_low;
    $rose(O_TIMER_OUTPUT) |-> mode_sh[OUTF_LSB+:2] != OUT_HELD_LOW;
  endproperty
  a_held_low: assert property (p_held_low)
    else $error("output rose while held low");
  property p_irq_cause;
    $rose(O_TIMER_IRQ_OUT) |-> en_sh[2:0] != 3'h0;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq rose with all enables off");
  property p_irq_clear;
    $fell(O_TIMER_IRQ_OUT) |-> $past(w1c) || $past(w1c, 2);
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("irq fell without flag clear");
endmodule

bind tcc_timer tcc_timer_sva #(.BUS_USED(BUS_USED)) u_sva (
  .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
  .O_TIMER_OUTPUT(O_TIMER_OUTPUT), .O_TIMER_IRQ_OUT(O_TIMER_IRQ_OUT));

// >>> testbench/tb_timer_counter_config.sv
// Purpose: self-checking bench for the timer block
// Assumes: short top value set by parameter to keep wraps quick
// Notes: counter pins are slow levels, eight system cycles each
`timescale 1ns/1ps
module tb_timer_counter_config;
  import tcc_pkg::*;
  localparam logic [15:0] TOP0 = 16'h0005;
  logic clk = 1'b0, rstn = 1'b0, tclk = 1'b0, osc = 1'b0, trst_n = 1'b1, capt = 1'b0;
  logic cyc, stb, we, ack, out, irq;
  logic [7:0] adr, wdat, rdat;
  int fails = 0, n_tests = 0;
  // 10 MHz system clock
  initial forever #50 clk = ~clk;
  tcc_timer #(.CFG_TOP(TOP0)) dut (.I_CLK_SYS(clk), .I_RESETN(rstn), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_TIMER_CLOCK_IN(tclk), .I_OSC_CLK(osc),
    .I_TIMER_RESET_LOW_N(trst_n), .I_CAPTURE_TRIGGER_IN(capt),
    .O_TIMER_OUTPUT(out), .O_TIMER_IRQ_OUT(irq));
  tcc_wb_master wbm (.i_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb),
    .o_we(we), .o_adr(adr), .o_dat(wdat));

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %b got %b", n, e, g);
    end
  endtask
  // bus access; a missing ack ends the run
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    bit ok;
    wbm.xfer(w, a, d, r, ok);
    if (!ok) begin
      fails++;
      $display("[ERR] ack at %h exp 1 got 0", a);
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    acc(1'b1, a, d, r);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    acc(1'b0, a, 8'h00, r);
    chk8(n, e, r);
  endtask
  task automatic cnt(input logic [15:0] e);
    rc("count lo", OFF_COUNT_LOW, e[7:0]);
    rc("count hi", OFF_COUNT_HIGH, e[15:8]);
  endtask
  // drive one counter pin and let the edge reach the count
  task automatic pin(input bit src, input logic v);
    @(negedge clk);
    if (src) osc = v;
    else tclk = v;
    repeat (7) @(negedge clk);
  endtask
  task automatic pulse(input bit src, input int n);
    repeat (n) begin
      pin(src, 1'b1);
      pin(src, 1'b0);
    end
  endtask

  // timer reset pin low for one edge so a period starts from a zero count
  task automatic trst;
    @(negedge clk);
    trst_n = 1'b0;
    @(negedge clk);
    trst_n = 1'b1;
  endtask

  task automatic t_reset;
    logic [7:0] r;
    bit ok;
    logic [7:0] e[12] = '{RST_CLOCK_SOURCE_CTRL, RST_MODE_CTRL, TOP0[7:0], TOP0[15:8],
      RST_COMPARE[7:0], RST_COMPARE[15:8], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      RST_IRQ_ENABLES};
    for (int i = 0; i < 12; i++) rc("reset value", ADDR_FIRST + 8'(i), e[i]);
    wr(8'h6A, 8'hFF);
    rc("unmapped", 8'h6A, 8'h00);
    wr(OFF_COUNT_LOW, 8'hFF);
    cnt(16'h0000);
    wbm.xfer(1'b0, 8'h70, 8'h00, r, ok);
    chk1("ack outside window", 1'b0, ok);
    $display("t_reset done");
  endtask

  task automatic t_count;
    wr(OFF_IRQ_ENABLES, 8'h01);
    wr(OFF_TOP_LOW, 8'h03);
    wr(OFF_TOP_HIGH, 8'h00);
    pulse(0, 6);
    cnt(16'h0000);
    rc("ovf flag", OFF_IRQ_FLAGS, 8'h01);
    chk1("irq", 1'b1, irq);
    pulse(0, 3);
    cnt(16'h0003);
    pulse(0, 1);
    cnt(16'h0000);
    wr(OFF_IRQ_FLAGS, 8'h01);
    rc("flag cleared", OFF_IRQ_FLAGS, 8'h00);
    chk1("irq cleared", 1'b0, irq);
    wr(OFF_IRQ_ENABLES, 8'h00);
    pulse(0, 6);
    cnt(16'h0002);
    rc("masked flag", OFF_IRQ_FLAGS, 8'h00);
    wr(OFF_MODE_CTRL, 8'h00);
    pulse(0, 2);
    cnt(16'h0002);
    wr(OFF_MODE_CTRL, 8'h20);
    pulse(0, 8);
    cnt(16'h0003);
    wr(OFF_MODE_CTRL, 8'h11);
    wr(OFF_CLOCK_SOURCE_CTRL, 8'h01);
    pulse(1, 2);
    pulse(0, 1);
    cnt(16'h0001);
    wr(OFF_CLOCK_SOURCE_CTRL, 8'h02);
    pin(0, 1'b1);
    cnt(16'h0001);
    pin(0, 1'b0);
    cnt(16'h0002);
    $display("t_count done");
  endtask

  task automatic t_capture;
    wr(OFF_CLOCK_SOURCE_CTRL, 8'h04);
    wr(OFF_IRQ_ENABLES, 8'h04);
    pin(0, 1'b0);
    capt = 1'b1;
    repeat (8) @(negedge clk);
    capt = 1'b0;
    rc("capture lo", OFF_CAPTURE_LOW, 8'h02);
    rc("capture hi", OFF_CAPTURE_HIGH, 8'h00);
    rc("capture flag", OFF_IRQ_FLAGS, 8'h04);
    chk1("irq", 1'b1, irq);
    wr(OFF_IRQ_FLAGS, 8'h04);
    rc("capture flag cleared", OFF_IRQ_FLAGS, 8'h00);
    $display("t_capture done");
  endtask

  // single slope: top 3 sets period, compare 2 sets duty
  task automatic t_pwm;
    logic [1:0] of[3] = '{2'h0, 2'h2, 2'h3};
    wr(OFF_COMPARE_LOW, 8'h02);
    wr(OFF_COMPARE_HIGH, 8'h00);
    trst();
    for (int m = 0; m < 3; m++) begin
      wr(OFF_MODE_CTRL, {4'h1, of[m], 2'h2});
      pulse(0, 4);
      for (int k = 1; k <= 4; k++) begin
        pulse(0, 1);
        chk1("output", (of[m] != 2'h0) && ((k == 3) ^ (of[m] == 2'h3)), out);
      end
    end
    $display("t_pwm done");
  endtask

  // dual slope, top 3 and compare 2: set going up, clear going down, period six ticks
  task automatic t_dual;
    logic [1:0] of[2] = '{2'h2, 2'h1};
    wr(OFF_IRQ_ENABLES, 8'h03);
    for (int m = 0; m < 2; m++) begin
      wr(OFF_MODE_CTRL, {4'h1, of[m], 2'h3});
      trst();
      for (int k = 1; k <= 6; k++) begin
        pulse(0, 1);
        chk1("dual output", (k == 3) || (k == 4), out);
      end
      cnt(16'h0000);
      rc("dual flags", OFF_IRQ_FLAGS, 8'h03);
      wr(OFF_IRQ_FLAGS, 8'h03);
    end
    $display("t_dual done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // reset for 10 cycles, then the scenarios in turn
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_count();
    t_capture();
    t_pwm();
    t_dual();
    test_done();
  end
endmodule
